// ### verification/can_timer_test.sv
`timescale 1ns/1ps

module can_timer_test;
    import can_timer_pkg::*;

    localparam int LIMIT = 100000;
    localparam logic [7:0] RA [10] = '{8'h9B, 8'h9C, 8'h9D, 8'hA4, 8'hA5,
        8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hB0};
    localparam logic [7:0] GM [4] = '{8'h02, 8'h22, 8'h0A, 8'h00};
    localparam logic [2:0] GX [4] = '{3'h7, 3'h5, 3'h0, 3'h0};

    logic clk = 1'b0;
    logic rstn = 1'b0;
    sfr_req_t sfr = '0;
    logic [3:0] page = 4'h0;
    logic irq_en = 1'b0;
    logic [7:0] sfr_rdata;
    logic irq;
    frame_evt_t fe;
    err_evt_t ee;
    cnt_evt_t ce;
    core_req_t creq;
    core_req_t grant;
    logic ena;
    logic [7:0] tec;
    logic [7:0] rec;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    // one tick per clock keeps a full wrap inside the run budget
    can_timer #(.TICK_DIV(8'h01)) uut
    (
        .clk(clk),
        .rstn(rstn),
        .sfr(sfr),
        .page(page),
        .sfr_rdata(sfr_rdata),
        .overflow_irq_enable(irq_en),
        .timer_overflow_irq(irq),
        .frame_evt(fe),
        .err_evt(ee),
        .cnt_evt(ce),
        .core_req(creq),
        .core_grant(grant),
        .controller_enable(ena),
        .tx_err_count(tec),
        .rx_err_count(rec)
    );

    proto_engine_model pe
    (
        .clk(clk),
        .frame_evt(fe),
        .err_evt(ee),
        .cnt_evt(ce),
        .core_req(creq)
    );

    always #12.5 clk = ~clk;

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a hang is counted as a mismatch
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            finish_test;
        end
    end

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // every bus task ends on a falling edge so event timing stays aligned
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        sfr <= '0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        sfr <= '0;
        @(negedge clk);
        d = {8'h00, sfr_rdata};
    endtask

    // low byte first, it latches the high byte
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [15:0] lo;
        logic [15:0] hi;
        rd(a, lo);
        rd(a + 8'h01, hi);
        v = {hi[7:0], lo[7:0]};
    endtask

    task automatic stamp(input logic [3:0] p, output logic [15:0] v);
        @(posedge clk);
        page <= p;
        rd16(8'hAE, v);
    endtask

    initial
    begin
        logic [15:0] b;
        logic [15:0] v1;
        logic [15:0] v2;
        logic [15:0] ca;
        logic [15:0] cb;
        int c1;
        int c2;
        int tgt;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);

        for (int i = 0; i < 10; i++)
            if (RA[i] != 8'hAB && RA[i] != 8'h9C && RA[i] != 8'h9D)
                wr(RA[i], 8'hFF);
        for (int i = 0; i < 10; i++)
        begin
            rd(RA[i], b);
            check("reset value", b, 16'h0000);
        end
        $display("test reset done");

        wr(8'hAB, 8'h02);
        rd(8'hAB, b);
        check("control", b, 16'h0002);
        c1 = cyc;
        rd16(8'hAC, v1);
        c2 = cyc;
        rd16(8'hAC, v2);
        check("timer step", v2 - v1, 16'(c2 - c1));
        $display("test count done");

        pe.frame(frame_evt_t'(8'h40));
        rd16(8'hA4, b);
        check("capture off", b, 16'h0000);
        wr(8'hAB, 8'h32);
        c1 = cyc;
        pe.frame(frame_evt_t'(8'h63));
        rd16(8'hA4, ca);
        stamp(4'h3, b);
        check("rx stamp", b, ca);
        pe.frame(frame_evt_t'(8'h80));
        rd16(8'hA4, b);
        check("sof ignored", b, ca);
        c2 = cyc;
        pe.frame(frame_evt_t'(8'h55));
        rd16(8'hA4, cb);
        check("eof capture", cb - ca, 16'(c2 - c1));
        stamp(4'h5, b);
        check("tx stamp", b, cb);
        stamp(4'h3, b);
        check("rx stamp kept", b, ca);
        stamp(4'hF, b);
        check("no channel", b, 16'h0000);
        wr(8'hAB, 8'h22);
        pe.frame(frame_evt_t'(8'h40));
        rd16(8'hA4, b);
        check("eof ignored", b, cb);
        c1 = cyc;
        pe.frame(frame_evt_t'(8'h80));
        rd16(8'hA4, b);
        check("sof capture", b - cb, 16'(c1 - c2));
        $display("test capture done");

        pe.request(core_req_t'(3'h7));
        for (int i = 0; i < 4; i++)
        begin
            wr(8'hAB, GM[i]);
            repeat (2) @(negedge clk);
            check("grant", {13'h0000, grant}, {13'h0000, GX[i]});
            check("enable", {15'h0000, ena}, {15'h0000, GM[i][1]});
        end
        pe.request(core_req_t'(3'h0));
        $display("test grant done");

        wr(8'hAB, 8'h0A);
        pe.error(err_evt_t'(5'h1F));
        pe.count(cnt_evt_t'(4'hA));
        rd(8'h9B, b);
        check("listen flags", b, 16'h009F);
        rd(8'h9C, b);
        check("tec frozen", b, 16'h0000);
        check("rec frozen", {8'h00, rec}, 16'h0000);
        repeat (40) @(negedge clk);
        rd(8'hAB, b);
        check("listen held", b, 16'h000A);
        wr(8'hAB, 8'h02);
        pe.count(cnt_evt_t'(4'hA));
        check("tec count", {8'h00, tec}, 16'h0001);
        rd(8'h9D, b);
        check("rec count", b, 16'h0001);
        wr(8'h9B, 8'h00);
        rd(8'h9B, b);
        check("flags cleared", b, 16'h0000);
        $display("test listen done");

        wr(8'hAB, 8'h00);
        rd16(8'hAC, v1);
        rd16(8'hAC, v2);
        check("timer held", v2, v1);
        wr(8'hAB, 8'h02);
        c1 = cyc;
        rd16(8'hAC, v1);
        tgt = c1 + 65536 - int'(v1);
        while (cyc < tgt - 8)
            @(negedge clk);
        rd(8'h9B, b);
        check("before wrap", b, 16'h0000);
        while (cyc < tgt + 8)
            @(negedge clk);
        rd(8'h9B, b);
        check("wrap flag", b, 16'h00A0);
        check("irq masked", {15'h0000, irq}, 16'h0000);
        @(posedge clk);
        irq_en <= 1'b1;
        repeat (3) @(negedge clk);
        check("irq raised", {15'h0000, irq}, 16'h0001);
        wr(8'h9B, 8'h00);
        rd(8'h9B, b);
        check("wrap cleared", b, 16'h0000);
        repeat (3) @(negedge clk);
        check("irq dropped", {15'h0000, irq}, 16'h0000);
        $display("test overflow done");
        finish_test;
    end
endmodule

// ### verification/proto_engine_model.sv
`timescale 1ns/1ps

module proto_engine_model
(
    // clock
    input wire logic clk,
    // events and requests toward the timer block
    output can_timer_pkg::frame_evt_t frame_evt,
    output can_timer_pkg::err_evt_t err_evt,
    output can_timer_pkg::cnt_evt_t cnt_evt,
    output can_timer_pkg::core_req_t core_req
);
    import can_timer_pkg::*;

    initial
    begin
        frame_evt = '0;
        err_evt = '0;
        cnt_evt = '0;
        core_req = '0;
    end

    // completion flags always travel with the channel that finished
    task automatic frame(input frame_evt_t f);
        @(posedge clk);
        frame_evt <= f;
        @(posedge clk);
        frame_evt <= '0;
        @(negedge clk);
    endtask

    task automatic error(input err_evt_t e);
        @(posedge clk);
        err_evt <= e;
        @(posedge clk);
        err_evt <= '0;
        @(negedge clk);
    endtask

    task automatic count(input cnt_evt_t c);
        @(posedge clk);
        cnt_evt <= c;
        @(posedge clk);
        cnt_evt <= '0;
        @(negedge clk);
    endtask

    // requests are levels, held until the engine drops them
    task automatic request(input core_req_t r);
        @(posedge clk);
        core_req <= r;
        @(negedge clk);
    endtask
endmodule

// ### verilog/can_timer.sv
// Functional notes
// R1 - sixteen-bit timer readable as two bytes
// R2 - timer counts only while controller enabled
// R3 - time-triggered mode captures timer on frame edge
// R4 - capture works only with time-triggered bit set
// R5 - time-triggered frames are never retransmitted
// R6 - each message stamps its channel register
// R7 - receive stamp taken with receive-complete event
// R8 - transmit stamp taken with transmit-complete event
// R9 - timer counts up and wraps to zero
// R10 - wrap raises overflow request when enabled
// R11 - listen-only mode sends no acknowledge
// R12 - listen-only mode starts no transmission
// R13 - listen-only mode still records error flags
// R14 - listen-only mode freezes both error counters
// R15 - software tunes bit timing until error-free
// R16 - only software leaves listen-only mode
// R17 - software clears overflow flag to acknowledge
// R18 - captures take both bytes from one cycle
// R19 - timer advances once per prescaled tick
`timescale 1ns/1ps
`include "can_timer_defines.svh"

module can_timer
#(
    parameter logic [7:0] TICK_DIV = `TICK_DIV_DEF
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // special function register port
    input wire can_timer_pkg::sfr_req_t sfr,
    input wire logic [3:0] page,
    output logic [7:0] sfr_rdata,
    // system interrupt enable
    input wire logic overflow_irq_enable,
    output logic timer_overflow_irq,
    // events from the protocol engine
    input wire can_timer_pkg::frame_evt_t frame_evt,
    input wire can_timer_pkg::err_evt_t err_evt,
    input wire can_timer_pkg::cnt_evt_t cnt_evt,
    input wire can_timer_pkg::core_req_t core_req,
    // grants back to the protocol engine
    output can_timer_pkg::core_req_t core_grant,
    output logic controller_enable,
    output logic [7:0] tx_err_count,
    output logic [7:0] rx_err_count
);
    import can_timer_pkg::*;

    gcon_t gcon, next_gcon;
    logic [15:0] timer, next_timer;
    logic [7:0] presc, next_presc;
    logic tick, wrap;
    logic [`GIT_FLAG_W-1:0] flags, next_flags;
    logic [7:0] tec, next_tec;
    logic [7:0] rec, next_rec;
    logic [7:0] high_shadow, next_high_shadow;
    logic [7:0] rdata, next_rdata;
    logic next_irq;
    core_req_t next_grant;
    logic ttc_load, stamp_load;
    logic [15:0] ttc_q, stamp_q;
    logic wr_gcon, wr_git, rd_timl;

    assign wr_gcon = sfr.wr && (sfr.addr == `ADDR_GCON);
    assign wr_git = sfr.wr && (sfr.addr == `ADDR_GIT);
    assign rd_timl = sfr.rd && (sfr.addr == `ADDR_TIML);

    // general control; mode bits change only on software writes
    always_comb
    begin
        next_gcon = gcon;
        // general reset bit clears itself after one cycle
        next_gcon.general_reset = 1'b0;
        if (wr_gcon)
        begin
            next_gcon = gcon_t'(sfr.wdata); // see R16
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gcon <= gcon_t'(`GCON_RST);
        end
        else
        begin
            gcon <= next_gcon;
        end
    end

    // prescaler and timer
    assign tick = gcon.enable && (presc == TICK_DIV - `PRESC_ONE);
    assign wrap = tick && (timer == `TIMER_MAX);

    always_comb
    begin
        next_presc = presc;
        next_timer = timer;
        if (gcon.general_reset)
        begin
            next_presc = `CNT_RST;
            next_timer = `WORD_ZERO;
        end
        else if (gcon.enable) // see R2
        begin
            next_presc = tick ? `CNT_RST : presc + `PRESC_ONE; // see R19
            if (tick)
            begin
                // natural 16-bit rollover gives the cyclic base
                next_timer = timer + `TIMER_ONE; // see R9
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            presc <= `CNT_RST;
            timer <= `WORD_ZERO;
        end
        else
        begin
            presc <= next_presc;
            timer <= next_timer;
        end
    end

    // time-triggered capture on start or end of frame
    assign ttc_load = gcon.time_triggered_mode_bit && gcon.enable &&
        (gcon.sync_eof ? frame_evt.eof : frame_evt.sof); // see R3 R4

    capture_word ttc_capture
    (
        .clk(clk),
        .rstn(rstn),
        .load(ttc_load),
        .value(timer),
        .q(ttc_q)
    );

    // channel stamping on completion events
    assign stamp_load = frame_evt.rx_ok || frame_evt.tx_ok; // see R7 R8

    stamp_bank stamps
    (
        .clk(clk),
        .rstn(rstn),
        .wr_en(stamp_load),
        .wr_idx(frame_evt.channel),
        .wr_data(timer),
        .rd_idx(page),
        .rd_data(stamp_q)
    );

    // sticky flags; writing 0 clears, a same-cycle event wins
    always_comb
    begin
        next_flags = flags;
        if (wr_git)
        begin
            next_flags = flags & sfr.wdata[`GIT_FLAG_W-1:0]; // see R17
        end
        if (wrap)
        begin
            next_flags[`GIT_TIMER_OVERFLOW_FLAG] = 1'b1; // see R10
        end
        if (err_evt.buffer_full)
        begin
            next_flags[`GIT_OVRBUF] = 1'b1;
        end
        // error flags keep updating in listen-only mode
        next_flags[3:0] = next_flags[3:0] | {err_evt.stuff_err,
            err_evt.crc_err, err_evt.form_err, err_evt.ack_err}; // see R13
        next_irq = next_flags[`GIT_TIMER_OVERFLOW_FLAG] && overflow_irq_enable; // see R10
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags <= `GIT_FLAG_RST;
            timer_overflow_irq <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            timer_overflow_irq <= next_irq;
        end
    end

    // error counters, frozen while only listening
    always_comb
    begin
        next_tec = tec;
        next_rec = rec;
        if (gcon.general_reset)
        begin
            next_tec = `CNT_RST;
            next_rec = `CNT_RST;
        end
        else if (!gcon.listen_only) // see R14
        begin
            if (cnt_evt.tec_up && tec != `CNT_MAX)
            begin
                next_tec = tec + `CNT_ONE;
            end
            else if (cnt_evt.tec_down && tec != `CNT_RST)
            begin
                next_tec = tec - `CNT_ONE;
            end
            if (cnt_evt.rec_up && rec != `CNT_MAX)
            begin
                next_rec = rec + `CNT_ONE;
            end
            else if (cnt_evt.rec_down && rec != `CNT_RST)
            begin
                next_rec = rec - `CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tec <= `CNT_RST;
            rec <= `CNT_RST;
        end
        else
        begin
            tec <= next_tec;
            rec <= next_rec;
        end
    end

    assign tx_err_count = tec;
    assign rx_err_count = rec;

    // grants to the protocol engine
    always_comb
    begin
        next_grant.tx_start = core_req.tx_start && gcon.enable &&
            !gcon.listen_only; // see R12
        // one shot only in time-triggered mode
        next_grant.retransmit = core_req.retransmit && gcon.enable &&
            !gcon.listen_only && !gcon.time_triggered_mode_bit; // see R5
        next_grant.ack = core_req.ack && gcon.enable &&
            !gcon.listen_only; // see R11
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core_grant <= '0;
            controller_enable <= 1'b0;
        end
        else
        begin
            core_grant <= next_grant;
            controller_enable <= next_gcon.enable;
        end
    end

    // register reads answer one cycle after the strobe
    always_comb
    begin
        next_high_shadow = high_shadow;
        next_rdata = rdata;
        if (rd_timl)
        begin
            // high byte frozen so a low-then-high read is coherent
            next_high_shadow = timer[15:8]; // see R1
        end
        if (sfr.rd)
        begin
            unique case (sfr.addr)
                `ADDR_GCON: next_rdata = gcon;
                `ADDR_GIT: next_rdata = {|flags, 1'b0, flags};
                `ADDR_TEC: next_rdata = tec;
                `ADDR_REC: next_rdata = rec;
                `ADDR_TIML: next_rdata = timer[7:0]; // see R1
                `ADDR_TIMH: next_rdata = high_shadow;
                `ADDR_TTCL: next_rdata = ttc_q[7:0];
                `ADDR_TTCH: next_rdata = ttc_q[15:8];
                `ADDR_STMPL: next_rdata = stamp_q[7:0];
                `ADDR_STMPH: next_rdata = stamp_q[15:8];
                default: next_rdata = `BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            high_shadow <= `BYTE_ZERO;
            rdata <= `BYTE_ZERO;
        end
        else
        begin
            high_shadow <= next_high_shadow;
            rdata <= next_rdata;
        end
    end

    assign sfr_rdata = rdata;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    timer_wrap_a: assert property (wrap && !gcon.general_reset |=> // see R9
        timer == `WORD_ZERO)
        else $error("timer did not wrap to zero");
    timer_idle_a: assert property (!gcon.enable |=> // see R2
        $stable(timer) || $past(gcon.general_reset))
        else $error("timer moved while controller disabled");
    timer_step_a: assert property (gcon.enable && // see R19
        !gcon.general_reset |=> timer == $past(timer) +
        ($past(tick) ? `TIMER_ONE : `WORD_ZERO))
        else $error("timer stepped off its tick");
    ttc_take_a: assert property (ttc_load |=> // see R3
        ttc_q == $past(timer))
        else $error("capture missed the frame edge");
    ttc_gate_a: assert property (!gcon.time_triggered_mode_bit |=> $stable(ttc_q)) // see R4
        else $error("capture outside time-triggered mode");
    // request follows the flag as it stands, so a clear also drops it
    ovf_flag_a: assert property (wrap |=> flags[`GIT_TIMER_OVERFLOW_FLAG] ##1 // see R10
        timer_overflow_irq == ($past(overflow_irq_enable) &&
        flags[`GIT_TIMER_OVERFLOW_FLAG]))
        else $error("overflow flag or request wrong");
    irq_gate_a: assert property (timer_overflow_irq |-> // see R10
        $past(overflow_irq_enable))
        else $error("overflow request without enable");
    one_shot_a: assert property (gcon.time_triggered_mode_bit |=> // see R5
        !core_grant.retransmit)
        else $error("retransmit granted in time-triggered mode");
    listen_tx_a: assert property (gcon.listen_only |=> // see R12
        !core_grant.tx_start && !core_grant.retransmit)
        else $error("transmission started while listening");
    listen_ack_a: assert property (gcon.listen_only |=> // see R11
        !core_grant.ack)
        else $error("acknowledge driven while listening");
    err_flags_a: assert property (err_evt.crc_err |=> flags[2]) // see R13
        else $error("error flag not recorded");
    cnt_freeze_a: assert property (gcon.listen_only && // see R14
        !gcon.general_reset |=> $stable(tec) && $stable(rec))
        else $error("error counter moved while listening");
    mode_hold_a: assert property (!wr_gcon |=> // see R16
        gcon.listen_only == $past(gcon.listen_only))
        else $error("listen-only mode changed without a write");

    wrap_seen_c: cover property (wrap ##1 timer_overflow_irq [*2]);
    ttc_eof_c: cover property (ttc_load && gcon.sync_eof);
    stamp_rx_c: cover property (frame_evt.rx_ok ##[1:20] frame_evt.tx_ok);
    listen_err_c: cover property (gcon.listen_only && err_evt.form_err);
endmodule

// ### verilog/can_timer_defines.svh
`ifndef CAN_TIMER_DEFINES_SVH
`define CAN_TIMER_DEFINES_SVH

// special function register addresses
`define ADDR_GIT     8'h9B
`define ADDR_TEC     8'h9C
`define ADDR_REC     8'h9D
`define ADDR_TTCL    8'hA4
`define ADDR_TTCH    8'hA5
`define ADDR_GCON    8'hAB
`define ADDR_TIML    8'hAC
`define ADDR_TIMH    8'hAD
`define ADDR_STMPL   8'hAE
`define ADDR_STMPH   8'hAF

// general interrupt flag register layout
`define GIT_SUMMARY  7
`define GIT_TIMER_OVERFLOW_FLAG   5
`define GIT_OVRBUF   4
`define GIT_FLAG_W   6
`define GIT_FLAG_RST 6'h00

// reset values, counter limit and step
`define GCON_RST     8'h00
`define BYTE_ZERO    8'h00
`define WORD_ZERO    16'h0000
`define CNT_RST      8'h00
`define CNT_MAX      8'hFF
`define CNT_ONE      8'h01

// timer
`define TIMER_MAX    16'hFFFF
`define TIMER_ONE    16'h0001
`define TICK_DIV_DEF 8'h08
`define PRESC_ONE    8'h01

// channels
`define NUM_CH       15
`define CH_W         4

`endif

// ### verilog/can_timer_pkg.sv
package can_timer_pkg;

    typedef struct packed {
        logic abort_req;
        logic overload_req;
        logic time_triggered_mode_bit;
        logic sync_eof;
        logic listen_only;
        logic test;
        logic enable;
        logic general_reset;
    } gcon_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic sof;
        logic eof;
        logic rx_ok;
        logic tx_ok;
        logic [3:0] channel;
    } frame_evt_t;

    typedef struct packed {
        logic buffer_full;
        logic stuff_err;
        logic crc_err;
        logic form_err;
        logic ack_err;
    } err_evt_t;

    typedef struct packed {
        logic tec_up;
        logic tec_down;
        logic rec_up;
        logic rec_down;
    } cnt_evt_t;

    typedef struct packed {
        logic tx_start;
        logic retransmit;
        logic ack;
    } core_req_t;

endpackage

// ### verilog/capture_word.sv
`timescale 1ns/1ps
`include "can_timer_defines.svh"

module capture_word
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // load side
    input wire logic load,
    input wire logic [15:0] value,
    // held copy
    output logic [15:0] q
);
    logic [15:0] next_q;

    // both bytes come from one cycle, never torn
    always_comb
    begin
        next_q = q;
        if (load)
        begin
            next_q = value; // see R18
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= `WORD_ZERO;
        end
        else
        begin
            q <= next_q;
        end
    end

    load_copy_a: assert property (@(posedge clk) // see R18
        disable iff (!rstn) load |=> q == $past(value))
        else $error("capture did not take the sampled word");
endmodule

// ### verilog/stamp_bank.sv
`timescale 1ns/1ps
`include "can_timer_defines.svh"

module stamp_bank
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // write side
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [15:0] wr_data,
    // read side
    input wire logic [3:0] rd_idx,
    output logic [15:0] rd_data
);
    logic [15:0] mem [`NUM_CH];
    logic [15:0] next_mem [`NUM_CH];

    always_comb
    begin
        for (int i = 0; i < `NUM_CH; i++)
        begin
            next_mem[i] = mem[i];
        end
        // page 15 has no channel behind it
        if (wr_en && (int'(wr_idx) < `NUM_CH))
        begin
            next_mem[wr_idx] = wr_data; // see R6
        end
        rd_data = `WORD_ZERO;
        if (int'(rd_idx) < `NUM_CH)
        begin
            rd_data = mem[rd_idx];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < `NUM_CH; i++)
            begin
                mem[i] <= `WORD_ZERO;
            end
        end
        else
        begin
            mem <= next_mem;
        end
    end

    stamp_write_a: assert property (@(posedge clk) // see R6
        disable iff (!rstn) (wr_en && int'(wr_idx) < `NUM_CH) |=>
        mem[$past(wr_idx)] == $past(wr_data))
        else $error("channel stamp not stored");
endmodule
